// file: common/sfcd_pkg.sv
// sfcd_pkg: opcodes, decode fields, states and timing of the serial flash host
// assumes a 100 MHz system clock and a flash left in 3-byte address mode
// Functional notes
// R1: 03h read, three address bytes, streaming
// R2: 0Bh/0Ch fast read, 3/4 address, 8 dummy
// R3: 13h read always four address bytes
// R4: 3Bh/3Ch dual output read, 8 dummy
// R5: BBh/BCh dual IO read, 4 or 8 dummy
// R6: 6Bh/6Ch quad output read, 8 dummy
// R7: EBh/ECh quad IO read, 6 or 10 dummy
// R8: 20h/21h 4K sector erase, no data
// R9: 52h/5Ch 32K block erase, no data
// R10: D8h/DCh 64K block erase, no data
// R11: 02h/12h page program, data follows address
// R12: 32h/34h program with quad data in
// R13: C2h/3Eh quad input page program
// R14: 06h alone sets write enable latch
// R15: 04h alone clears write enable latch
// R16: 50h alone permits volatile status write
// R17: 36h lock, 39h unlock, 3Dh query block
// R18: 7Eh alone locks every block
// R19: 98h alone unlocks every block
// R20: 44h/42h/48h secure area, 48h eight dummy
// R21: 05h returns status register one byte
// R22: 35h returns status register two byte
// R23: unknown opcode idles device until reselect
// R24: sample on rising edge, shift on falling
// R25: chip select rises only at byte boundary
// R26: device supplies upper bits in 3-byte mode
// R27: early deselect abandons command without change
package sfcd_pkg;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned SCLK_HALF_NS = 40;
  localparam int unsigned CS_HIGH_NS   = 50;
  localparam int unsigned HALF_CYC     = (SCLK_HALF_NS * CLK_MHZ) / 1000;
  localparam int unsigned CSH_CYC      = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  TICK_RISE    = 4'(HALF_CYC - 1);
  localparam logic [3:0]  TICK_LAST    = 4'(2 * HALF_CYC - 1);
  localparam logic [3:0]  TICK_CSH     = 4'(CSH_CYC - 1);
  localparam int unsigned FIFO_WIDTH   = 8;
  localparam int unsigned FIFO_DEPTH   = 16;

  typedef logic [7:0] sfcd_op_t;
  localparam sfcd_op_t OP_ARRAY_READ = 8'h03;
  localparam sfcd_op_t OP_ARRAY_READ_WIDE = 8'h13;
  localparam sfcd_op_t OP_FAST_READ = 8'h0b;
  localparam sfcd_op_t OP_FAST_READ_WIDE = 8'h0c;
  localparam sfcd_op_t OP_DUAL_OUT_READ = 8'h3b;
  localparam sfcd_op_t OP_DUAL_OUT_READ_WIDE = 8'h3c;
  localparam sfcd_op_t OP_DUAL_IO_READ = 8'hbb;
  localparam sfcd_op_t OP_DUAL_IO_READ_WIDE = 8'hbc;
  localparam sfcd_op_t OP_QUAD_OUT_READ = 8'h6b;
  localparam sfcd_op_t OP_QUAD_OUT_READ_WIDE = 8'h6c;
  localparam sfcd_op_t OP_QUAD_IO_READ = 8'heb;
  localparam sfcd_op_t OP_QUAD_IO_READ_WIDE = 8'hec;
  localparam sfcd_op_t OP_SECTOR_ERASE = 8'h20;
  localparam sfcd_op_t OP_SECTOR_ERASE_WIDE = 8'h21;
  localparam sfcd_op_t OP_HALF_BLOCK_ERASE = 8'h52;
  localparam sfcd_op_t OP_HALF_BLOCK_ERASE_WIDE = 8'h5c;
  localparam sfcd_op_t OP_BLOCK_ERASE = 8'hd8;
  localparam sfcd_op_t OP_BLOCK_ERASE_WIDE = 8'hdc;
  localparam sfcd_op_t OP_PAGE_PROGRAM = 8'h02;
  localparam sfcd_op_t OP_PAGE_PROGRAM_WIDE = 8'h12;
  localparam sfcd_op_t OP_QUAD_DATA_PROGRAM = 8'h32;
  localparam sfcd_op_t OP_QUAD_DATA_PROGRAM_WIDE = 8'h34;
  localparam sfcd_op_t OP_QUAD_INPUT_PROGRAM = 8'hc2;
  localparam sfcd_op_t OP_QUAD_INPUT_PROGRAM_WIDE = 8'h3e;
  localparam sfcd_op_t OP_WRITE_LATCH_SET = 8'h06;
  localparam sfcd_op_t OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam sfcd_op_t OP_VOLATILE_STATUS_PERMIT = 8'h50;
  localparam sfcd_op_t OP_BLOCK_LOCK = 8'h36;
  localparam sfcd_op_t OP_BLOCK_UNLOCK = 8'h39;
  localparam sfcd_op_t OP_BLOCK_LOCK_QUERY = 8'h3d;
  localparam sfcd_op_t OP_GLOBAL_LOCK = 8'h7e;
  localparam sfcd_op_t OP_GLOBAL_UNLOCK = 8'h98;
  localparam sfcd_op_t OP_SECURE_ERASE = 8'h44;
  localparam sfcd_op_t OP_SECURE_PROGRAM = 8'h42;
  localparam sfcd_op_t OP_SECURE_READ = 8'h48;
  localparam sfcd_op_t OP_STATUS_ONE_READ = 8'h05;
  localparam sfcd_op_t OP_STATUS_TWO_READ = 8'h35;

  localparam logic [2:0] A0 = 3'h0;
  localparam logic [2:0] A3 = 3'h3;
  localparam logic [2:0] A4 = 3'h4;
  localparam logic [3:0] D0 = 4'h0;
  localparam logic [3:0] D4 = 4'h4;
  localparam logic [3:0] D6 = 4'h6;
  localparam logic [3:0] D8 = 4'h8;
  localparam logic [3:0] D10 = 4'ha;
  localparam logic [2:0] L1 = 3'h1;
  localparam logic [2:0] L2 = 3'h2;
  localparam logic [2:0] L4 = 3'h4;

  typedef enum logic [1:0] {DIR_NONE, DIR_READ, DIR_WRITE} sfcd_dir_e;
  typedef enum {ST_IDLE, ST_SHIFT, ST_END} sfcd_state_e;
  typedef enum {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA} sfcd_phase_e;

  typedef struct packed {
    logic       known;
    logic [2:0] abytes;
    logic [3:0] dummy;
    logic [3:0] dummy_alt;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    sfcd_dir_e  dir;
  } sfcd_dec_s;
endpackage

// file: sim/sfcd_flash_model.sv
// sfcd_flash_model: flash answering status reads and write latch
// assumes mode 0; undriven lines toggle on each falling edge
`timescale 1ns/1ps
module sfcd_flash_model #(
  parameter logic [7:0] STAT_TWO = 8'h5a
) (
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [31:0] shift_o
);
  logic [7:0] op_q = 8'h00;
  logic [6:0] cnt_q = 7'h00;
  logic       wel_q = 1'b0;
  logic [7:0] byte_w;
  // latch bit place is arbitrary; other bits zero
  assign byte_w = (op_q == 8'h05) ? {6'h00, wel_q, 1'b0} : STAT_TWO;
  initial io_o = 4'h5;
  initial shift_o = 32'h0;
  always @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      // only a one-byte frame commits
      if (cnt_q == 7'h08 && op_q == 8'h06) wel_q <= 1'b1;
      if (cnt_q == 7'h08 && op_q == 8'h04) wel_q <= 1'b0;
      cnt_q <= 7'h00;
    end
    else
    begin
      shift_o <= {shift_o[30:0], io_i[0]};
      cnt_q <= cnt_q + 7'h01;
      if (cnt_q == 7'h07) op_q <= {shift_o[6:0], io_i[0]};
    end
  end
  always @(negedge sclk_i)
  begin
    // released lines never hold a stale level
    io_o <= ~io_o;
    if (!cs_n_i && cnt_q[6:3] == 4'h1 && (op_q == 8'h05 || op_q == 8'h35))
      io_o[1] <= byte_w[4'hf - cnt_q[3:0]];
  end
endmodule

// file: sim/sfcd_host_sva.sv
// sfcd_host_chk: port checker for sfcd_host
// assumes binding into sfcd_host; sees only its ports
`timescale 1ns/1ps
module sfcd_host_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_ready_o,
  input wire logic       cmd_err_o,
  input wire logic       done_o,
  input wire logic       rd_valid_o,
  input wire logic       cs_n_o,
  input wire logic       sclk_o,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_taken;
    cmd_valid_i && cmd_ready_o ##1 !cmd_err_o;
  endsequence
  sequence s_gap;
    (cs_n_o && !cmd_ready_o) [*5];
  endsequence
  sequence s_high;
    sclk_o [*4] ##1 !sclk_o;
  endsequence
  property p_err_idle; cmd_err_o |-> cmd_ready_o && cs_n_o ##1 cs_n_o; endproperty
  a_err_idle: assert property (p_err_idle) else $error("err frame");
  property p_take; s_taken |-> !cs_n_o && !cmd_ready_o; endproperty
  a_take: assert property (p_take) else $error("no select");
  property p_done; $rose(cs_n_o) |-> done_o; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_gap; done_o |-> s_gap; endproperty
  a_gap: assert property (p_gap) else $error("cs gap");
  property p_idle; cs_n_o |-> !sclk_o; endproperty
  a_idle: assert property (p_idle) else $error("sclk idle");
  property p_high; $rose(sclk_o) |-> s_high; endproperty
  a_high: assert property (p_high) else $error("sclk high");
  property p_stable; sclk_o |-> $stable({io_o, io_oe_o}); endproperty
  a_stable: assert property (p_stable) else $error("io moved");
  property p_rd; rd_valid_o |-> !$past(cs_n_o); endproperty
  a_rd: assert property (p_rd) else $error("rd frame");
endmodule
bind sfcd_host sfcd_host_chk sfcd_host_chk_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .cmd_err_o(cmd_err_o), .done_o(done_o), .rd_valid_o(rd_valid_o), .cs_n_o(cs_n_o),
  .sclk_o(sclk_o), .io_o(io_o), .io_oe_o(io_oe_o)
);

// file: sim/tb_top.sv
// tb_top: self-checking bench, sfcd_host and flash model
// assumes 100 MHz clock; expectations from the opcode table
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic [7:0]  cmd_op_i = 8'h00;
  logic [31:0] cmd_addr_i = 32'hc3a5_5a3c;
  logic [15:0] cmd_len_i = 16'h0001;
  logic        cmd_alt_dummy_i = 1'b0;
  logic        wr_valid_i = 1'b0;
  logic [7:0]  wr_data_i = 8'h00;
  logic        cmd_ready_o, cmd_err_o, done_o, wr_ready_o, rd_valid_o, cs_n_o, sclk_o;
  logic [7:0]  rd_data_o, rd_last;
  logic [3:0]  io_o, io_oe_o, io_i, dev_io;
  logic [31:0] dev_shift;
  int          n_fail = 0, n_tests = 0, rises = 0, n_err = 0;
  logic [7:0]  ops[39] = '{8'h03, 8'h0b, 8'h0c, 8'h13, 8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'h6b,
    8'h6c, 8'heb, 8'hec, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'h02, 8'h12, 8'h32,
    8'h34, 8'hc2, 8'h3e, 8'h06, 8'h04, 8'h50, 8'h36, 8'h39, 8'h3d, 8'h7e, 8'h98, 8'h44,
    8'h42, 8'h48, 8'h05, 8'h35, 8'hbb, 8'heb};
  int          rs[39] = '{40, 48, 56, 48, 44, 52, 28, 32, 42, 50, 22, 24, 32, 40, 32, 40,
    32, 40, 40, 48, 34, 42, 16, 18, 8, 8, 8, 32, 32, 40, 8, 8, 32, 40, 48, 16, 16, 32, 26};
  always #5 clk_i = ~clk_i;
  assign io_i = (io_o & io_oe_o) | (dev_io & ~io_oe_o);
  always @(posedge sclk_o) rises <= rises + 1;
  always @(posedge clk_i)
  begin
    if (rd_valid_o === 1'b1) rd_last <= rd_data_o;
    if (cmd_err_o === 1'b1) n_err <= n_err + 1;
  end
  sfcd_host sfcd_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_len_i(cmd_len_i), .cmd_alt_dummy_i(cmd_alt_dummy_i), .cmd_err_o(cmd_err_o),
    .done_o(done_o), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .cs_n_o(cs_n_o), .sclk_o(sclk_o),
    .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i));
  sfcd_flash_model sfcd_flash_model_inst (.cs_n_i(cs_n_o), .sclk_i(sclk_o), .io_i(io_i),
    .io_o(dev_io), .shift_o(dev_shift));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic issue(input logic [7:0] op, input logic alt = 1'b0,
    input logic [15:0] len = 16'h0001);
    @(posedge clk_i);
    rises = 0;
    cmd_op_i <= op;
    cmd_alt_dummy_i <= alt;
    cmd_len_i <= len;
    cmd_valid_i <= 1'b1;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (cmd_ready_o !== 1'b1) @(posedge clk_i);
  endtask
  // valid held over a full fifo to test refusal
  task automatic push(input int n, output int got);
    got = 0;
    @(posedge clk_i);
    wr_valid_i <= 1'b1;
    repeat (n)
    begin
      @(posedge clk_i);
      if (wr_ready_o === 1'b1)
      begin
        got++;
        wr_data_i <= wr_data_i + 8'h01;
      end
    end
    wr_valid_i <= 1'b0;
  endtask
  task automatic t_reset();
    repeat (6) @(posedge clk_i);
    chk("reset", {20'h0, cs_n_o, sclk_o, cmd_ready_o, wr_ready_o, io_oe_o, io_o},
      32'hbcc);
    rst_n_i <= 1'b1;
  endtask
  task automatic t_refuse();
    issue(8'h60);
    chk("errors", n_err, 32'h1);
    chk("sclks", rises, 32'h0);
  endtask
  task automatic t_sweep();
    int g;
    for (int i = 0; i < 39; i++)
    begin
      if (ops[i] inside {8'h02, 8'h12, 8'h32, 8'h34, 8'hc2, 8'h3e, 8'h42}) push(1, g);
      issue(ops[i], i > 36);
      chk("sclks", rises, rs[i]);
      if (ops[i] == 8'h20) chk("addr3", {8'h0, dev_shift[23:0]}, {8'h0, cmd_addr_i[23:0]});
      if (ops[i] == 8'h21) chk("addr4", dev_shift, cmd_addr_i);
    end
  endtask
  task automatic t_status();
    issue(8'h06);
    issue(8'h05);
    chk("stat1", {24'h0, rd_last}, 32'h02);
    issue(8'h04);
    issue(8'h05);
    chk("stat1", {24'h0, rd_last}, 32'h00);
    issue(8'h35);
    chk("stat2", {24'h0, rd_last}, 32'h5a);
  endtask
  task automatic t_fifo();
    int g;
    logic [7:0] b;
    b = wr_data_i;
    push(20, g);
    chk("taken", g, 32'h10);
    issue(8'h02, 1'b0, 16'h0010);
    chk("sclks", rises, 32'd160);
    chk("tail", dev_shift, {b + 8'h0c, b + 8'h0d, b + 8'h0e, b + 8'h0f});
    chk("wr ready", {31'h0, wr_ready_o}, 32'h1);
  endtask
  initial
  begin
    t_reset();
    t_refuse();
    t_sweep();
    t_status();
    t_fifo();
    summarize();
  end
  initial
  begin
    #1000000;
    n_fail++;
    summarize();
  end
endmodule

// file: verilog/sfcd_host.sv
// sfcd_host: host controller that issues serial flash commands over four io lines,
// plus the write data fifo that feeds its program phase
// assumes the flash sits on cs_n_o/sclk_o/io and that io_i is asynchronous
`timescale 1ns/1ps

module sfcd_fifo #(
  parameter int unsigned WIDTH = sfcd_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = sfcd_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // ready is registered from the next count so it never depends on the writer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_q       <= '0;
      rp_q       <= '0;
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q      <= cnt_d;
      in_ready_o <= (cnt_d < (AW+1)'(DEPTH));
    end
  end
endmodule

module sfcd_host (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  cmd_op_i,
  input  wire logic [31:0] cmd_addr_i,
  input  wire logic [15:0] cmd_len_i,
  input  wire logic        cmd_alt_dummy_i,
  output logic             cmd_err_o,
  output logic             done_o,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [7:0]  wr_data_i,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  output logic             cs_n_o,
  output logic             sclk_o,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_o,
  input  wire logic [3:0]  io_i
);
  sfcd_pkg::sfcd_state_e st_q;
  sfcd_pkg::sfcd_phase_e ph_q;
  sfcd_pkg::sfcd_phase_e nxt_ph;
  sfcd_pkg::sfcd_dec_s   dec_q;
  sfcd_pkg::sfcd_dec_s   cmd_dec;
  logic                  nxt_done;
  logic [7:0]            sh_q;
  logic [31:0]           addr_q;
  logic [2:0]            abytes_q;
  logic [3:0]            dmy_q;
  logic [15:0]           dcnt_q;
  logic [3:0]            bits_q;
  logic [3:0]            tick_q;
  logic [2:0]            lanes_q;
  logic                  drive_q;
  logic                  is_write;
  logic                  stall;
  logic                  adv;
  logic                  pop;
  logic                  fifo_valid;
  logic [7:0]            fifo_data;
  logic [3:0]            s1_q;
  logic [3:0]            s2_q;
  logic [3:0]            s3_q;
  logic [3:0]            io_in_q;

  function automatic sfcd_pkg::sfcd_dec_s mk_f(
    input logic [2:0]          ab,
    input logic [3:0]          dm,
    input logic [3:0]          da,
    input logic [2:0]          al,
    input logic [2:0]          dl,
    input sfcd_pkg::sfcd_dir_e dr
  );
    sfcd_pkg::sfcd_dec_s d;
    d.known     = 1'b1;
    d.abytes    = ab;
    d.dummy     = dm;
    d.dummy_alt = da;
    d.alanes    = al;
    d.dlanes    = dl;
    d.dir       = dr;
    return d;
  endfunction

  // opcodes outside this set are refused here, never sent to the flash
  function automatic sfcd_pkg::sfcd_dec_s dec_f(input logic [7:0] op);
    sfcd_pkg::sfcd_dec_s d;
    d = '0;
    case (op)
      sfcd_pkg::OP_ARRAY_READ:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R1
      sfcd_pkg::OP_FAST_READ:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D8, sfcd_pkg::D8, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R2
      sfcd_pkg::OP_FAST_READ_WIDE:
        d = mk_f(sfcd_pkg::A4, sfcd_pkg::D8, sfcd_pkg::D8, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R2
      sfcd_pkg::OP_ARRAY_READ_WIDE:
        d = mk_f(sfcd_pkg::A4, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R3
      sfcd_pkg::OP_DUAL_OUT_READ, sfcd_pkg::OP_DUAL_OUT_READ_WIDE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D8, sfcd_pkg::D8, sfcd_pkg::L1, sfcd_pkg::L2,
                 sfcd_pkg::DIR_READ); // R4
      sfcd_pkg::OP_DUAL_IO_READ, sfcd_pkg::OP_DUAL_IO_READ_WIDE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D4, sfcd_pkg::D8, sfcd_pkg::L2, sfcd_pkg::L2,
                 sfcd_pkg::DIR_READ); // R5
      sfcd_pkg::OP_QUAD_OUT_READ, sfcd_pkg::OP_QUAD_OUT_READ_WIDE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D8, sfcd_pkg::D8, sfcd_pkg::L1, sfcd_pkg::L4,
                 sfcd_pkg::DIR_READ); // R6
      sfcd_pkg::OP_QUAD_IO_READ, sfcd_pkg::OP_QUAD_IO_READ_WIDE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D6, sfcd_pkg::D10, sfcd_pkg::L4, sfcd_pkg::L4,
                 sfcd_pkg::DIR_READ); // R7
      sfcd_pkg::OP_SECTOR_ERASE, sfcd_pkg::OP_SECTOR_ERASE_WIDE,
      sfcd_pkg::OP_HALF_BLOCK_ERASE, sfcd_pkg::OP_HALF_BLOCK_ERASE_WIDE,
      sfcd_pkg::OP_BLOCK_ERASE, sfcd_pkg::OP_BLOCK_ERASE_WIDE,
      sfcd_pkg::OP_BLOCK_LOCK, sfcd_pkg::OP_BLOCK_UNLOCK, sfcd_pkg::OP_SECURE_ERASE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_NONE); // R8 R9 R10 R17 R20
      sfcd_pkg::OP_PAGE_PROGRAM, sfcd_pkg::OP_PAGE_PROGRAM_WIDE, sfcd_pkg::OP_SECURE_PROGRAM:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_WRITE); // R11 R20
      sfcd_pkg::OP_QUAD_DATA_PROGRAM, sfcd_pkg::OP_QUAD_DATA_PROGRAM_WIDE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L4,
                 sfcd_pkg::DIR_WRITE); // R12
      sfcd_pkg::OP_QUAD_INPUT_PROGRAM, sfcd_pkg::OP_QUAD_INPUT_PROGRAM_WIDE:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L4, sfcd_pkg::L4,
                 sfcd_pkg::DIR_WRITE); // R13
      sfcd_pkg::OP_WRITE_LATCH_SET, sfcd_pkg::OP_WRITE_LATCH_CLEAR,
      sfcd_pkg::OP_VOLATILE_STATUS_PERMIT, sfcd_pkg::OP_GLOBAL_LOCK,
      sfcd_pkg::OP_GLOBAL_UNLOCK:
        d = mk_f(sfcd_pkg::A0, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_NONE); // R14 R15 R16 R18 R19
      sfcd_pkg::OP_BLOCK_LOCK_QUERY:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R17
      sfcd_pkg::OP_SECURE_READ:
        d = mk_f(sfcd_pkg::A3, sfcd_pkg::D8, sfcd_pkg::D8, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R20
      sfcd_pkg::OP_STATUS_ONE_READ, sfcd_pkg::OP_STATUS_TWO_READ:
        d = mk_f(sfcd_pkg::A0, sfcd_pkg::D0, sfcd_pkg::D0, sfcd_pkg::L1, sfcd_pkg::L1,
                 sfcd_pkg::DIR_READ); // R21 R22
      default:
        d = '0;
    endcase
    // wide-address opcodes carry four bytes whatever the address mode
    case (op)
      sfcd_pkg::OP_ARRAY_READ_WIDE, sfcd_pkg::OP_FAST_READ_WIDE,
      sfcd_pkg::OP_DUAL_OUT_READ_WIDE, sfcd_pkg::OP_DUAL_IO_READ_WIDE,
      sfcd_pkg::OP_QUAD_OUT_READ_WIDE, sfcd_pkg::OP_QUAD_IO_READ_WIDE,
      sfcd_pkg::OP_SECTOR_ERASE_WIDE, sfcd_pkg::OP_HALF_BLOCK_ERASE_WIDE,
      sfcd_pkg::OP_BLOCK_ERASE_WIDE, sfcd_pkg::OP_PAGE_PROGRAM_WIDE,
      sfcd_pkg::OP_QUAD_DATA_PROGRAM_WIDE, sfcd_pkg::OP_QUAD_INPUT_PROGRAM_WIDE:
        d.abytes = sfcd_pkg::A4; // R2 R3
      default:
        d.abytes = d.abytes;
    endcase
    return d;
  endfunction

  // clock slots needed to move one byte over the given number of lines
  function automatic logic [3:0] slots_f(input logic [2:0] lanes);
    case (lanes)
      sfcd_pkg::L2: slots_f = 4'h4;
      sfcd_pkg::L4: slots_f = 4'h2;
      default:      slots_f = 4'h8;
    endcase
  endfunction

  assign cmd_dec = dec_f(cmd_op_i);

  // three-stage input synchroniser; a bit moves only when stages two and three agree
  for (genvar b = 0; b < 4; b++)
  begin : g_sync
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        s1_q[b]    <= 1'b0;
        s2_q[b]    <= 1'b0;
        s3_q[b]    <= 1'b0;
        io_in_q[b] <= 1'b0;
      end
      else
      begin
        s1_q[b] <= io_i[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b])
        begin
          io_in_q[b] <= s3_q[b];
        end
      end
    end
  end

  always_comb
  begin
    nxt_ph   = sfcd_pkg::PH_DATA;
    nxt_done = 1'b0;
    if ((ph_q == sfcd_pkg::PH_CMD || ph_q == sfcd_pkg::PH_ADDR) && abytes_q != sfcd_pkg::A0)
    begin
      nxt_ph = sfcd_pkg::PH_ADDR;
    end
    else if ((ph_q == sfcd_pkg::PH_CMD || ph_q == sfcd_pkg::PH_ADDR) && dmy_q != sfcd_pkg::D0)
    begin
      nxt_ph = sfcd_pkg::PH_DUMMY;
    end
    else if (dec_q.dir == sfcd_pkg::DIR_NONE || dcnt_q == '0)
    begin
      nxt_done = 1'b1;
    end
  end

  assign is_write = (dec_q.dir == sfcd_pkg::DIR_WRITE);
  // program data not yet in the fifo parks the clock low between bytes
  assign stall    = !nxt_done && nxt_ph == sfcd_pkg::PH_DATA && is_write && !fifo_valid;
  assign adv      = (st_q == sfcd_pkg::ST_SHIFT) && (bits_q == '0) && !stall;
  assign pop      = adv && !nxt_done && nxt_ph == sfcd_pkg::PH_DATA && is_write;

  sfcd_fifo #(
    .WIDTH (sfcd_pkg::FIFO_WIDTH),
    .DEPTH (sfcd_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data)
  );

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q        <= sfcd_pkg::ST_IDLE;
      ph_q        <= sfcd_pkg::PH_CMD;
      dec_q       <= '0;
      sh_q        <= '0;
      addr_q      <= '0;
      abytes_q    <= '0;
      dmy_q       <= '0;
      dcnt_q      <= '0;
      bits_q      <= '0;
      tick_q      <= '0;
      lanes_q     <= sfcd_pkg::L1;
      drive_q     <= 1'b0;
      cs_n_o      <= 1'b1;
      sclk_o      <= 1'b0;
      cmd_ready_o <= 1'b1;
      cmd_err_o   <= 1'b0;
      done_o      <= 1'b0;
    end
    else
    begin
      cmd_err_o <= 1'b0;
      done_o    <= 1'b0;
      case (st_q)
        sfcd_pkg::ST_IDLE:
        begin
          if (cmd_valid_i && cmd_ready_o)
          begin
            if (!cmd_dec.known)
            begin
              cmd_err_o <= 1'b1; // R23
            end
            else
            begin
              cmd_ready_o <= 1'b0;
              st_q        <= sfcd_pkg::ST_SHIFT;
              cs_n_o      <= 1'b0;
              ph_q        <= sfcd_pkg::PH_CMD;
              dec_q       <= cmd_dec;
              dmy_q       <= cmd_alt_dummy_i ? cmd_dec.dummy_alt : cmd_dec.dummy; // R5 R7
              abytes_q    <= cmd_dec.abytes;
              // narrow mode sends the low 24 bits; the flash adds the upper ones
              addr_q      <= (cmd_dec.abytes == sfcd_pkg::A4) ? cmd_addr_i
                             : {cmd_addr_i[23:0], 8'h00}; // R26
              dcnt_q      <= cmd_len_i;
              sh_q        <= cmd_op_i;
              lanes_q     <= sfcd_pkg::L1;
              bits_q      <= slots_f(sfcd_pkg::L1);
              drive_q     <= 1'b1;
              tick_q      <= '0;
            end
          end
        end
        sfcd_pkg::ST_SHIFT:
        begin
          if (bits_q != '0)
          begin
            tick_q <= (tick_q == sfcd_pkg::TICK_LAST) ? '0 : tick_q + 4'h1;
            if (tick_q == sfcd_pkg::TICK_RISE)
            begin
              sclk_o <= 1'b1; // R24
            end
            if (tick_q == sfcd_pkg::TICK_LAST)
            begin
              // sample at the end of the high phase, then drop the clock
              sclk_o <= 1'b0; // R24
              bits_q <= bits_q - 4'h1;
              case (lanes_q)
                sfcd_pkg::L2: sh_q <= {sh_q[5:0], io_in_q[1:0]};
                sfcd_pkg::L4: sh_q <= {sh_q[3:0], io_in_q};
                default:      sh_q <= {sh_q[6:0], io_in_q[1]};
              endcase
            end
          end
          else if (adv)
          begin
            ph_q <= nxt_ph;
            if (nxt_done)
            begin
              // only whole bytes are ever framed
              st_q   <= sfcd_pkg::ST_END; // R25 R27
              cs_n_o <= 1'b1; // R25
              done_o <= 1'b1;
              tick_q <= '0;
            end
            else
            begin
              case (nxt_ph)
                sfcd_pkg::PH_ADDR:
                begin
                  sh_q     <= addr_q[31:24];
                  addr_q   <= {addr_q[23:0], 8'h00};
                  abytes_q <= abytes_q - 3'h1;
                  lanes_q  <= dec_q.alanes;
                  bits_q   <= slots_f(dec_q.alanes);
                  drive_q  <= 1'b1;
                end
                sfcd_pkg::PH_DUMMY:
                begin
                  sh_q    <= '0;
                  lanes_q <= dec_q.dlanes;
                  bits_q  <= dmy_q;
                  drive_q <= 1'b0;
                end
                default:
                begin
                  sh_q    <= is_write ? fifo_data : 8'h00;
                  dcnt_q  <= dcnt_q - 16'h0001;
                  lanes_q <= dec_q.dlanes;
                  bits_q  <= slots_f(dec_q.dlanes);
                  drive_q <= is_write;
                end
              endcase
            end
          end
        end
        sfcd_pkg::ST_END:
        begin
          // hold chip select high for the minimum deselect time
          if (tick_q == sfcd_pkg::TICK_CSH)
          begin
            st_q        <= sfcd_pkg::ST_IDLE;
            cmd_ready_o <= 1'b1;
            tick_q      <= '0;
          end
          else
          begin
            tick_q <= tick_q + 4'h1;
          end
        end
        default:
        begin
          st_q <= sfcd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // io2/io3 double as write-protect and hold; kept high except in four-line phases, where they drive quad bits or are released
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      io_o    <= 4'hc;
      io_oe_o <= 4'hc;
    end
    else if (st_q != sfcd_pkg::ST_SHIFT)
    begin
      io_o    <= 4'hc;
      io_oe_o <= 4'hc;
    end
    else
    begin
      case (lanes_q)
        sfcd_pkg::L2:
        begin
          io_o    <= drive_q ? {2'b11, sh_q[7:6]} : 4'hc;
          io_oe_o <= drive_q ? 4'hf : 4'hc;
        end
        sfcd_pkg::L4:
        begin
          io_o    <= drive_q ? sh_q[7:4] : 4'h0;
          io_oe_o <= drive_q ? 4'hf : 4'h0;
        end
        default:
        begin
          io_o    <= {3'b110, drive_q & sh_q[7]};
          io_oe_o <= 4'hd;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end
    else
    begin
      rd_valid_o <= adv && ph_q == sfcd_pkg::PH_DATA && dec_q.dir == sfcd_pkg::DIR_READ;
      if (adv && ph_q == sfcd_pkg::PH_DATA && dec_q.dir == sfcd_pkg::DIR_READ)
      begin
        rd_data_o <= sh_q;
      end
    end
  end
endmodule
